// [include/cog_map.vh]
// Register map and constants for the gated clock fanout control block
`ifndef COG_MAP_VH
`define COG_MAP_VH
// ==========================================
// Register indexes
`define COG_IDX_RSVD_A   7'h00
`define COG_IDX_RSVD_B   7'h01
`define COG_IDX_GATE     7'h02
`define COG_IDX_REV      7'h03
`define COG_IDX_LEN      7'h04
// ==========================================
// Reset values
`define COG_RST_RSVD_A   8'h00
`define COG_RST_RSVD_B   8'h00
`define COG_RST_GATE     8'hc0
`define COG_RST_LEN      8'h06
// ==========================================
// Field positions in the gate register
`define COG_BIT_OUT_ZERO 7
`define COG_BIT_OUT_ONE  6
// ==========================================
// Serial slave address, upper seven bits
`define COG_SLAVE_ADDR   7'h6b
// Command bit that marks a single-byte access
`define COG_CMD_BYTE_BIT 7
// ==========================================
// Enable latency bounds, in output clock cycles
`define COG_EN_LAT_MIN   2
`define COG_EN_LAT_MAX   6
`endif

// [rtl/cog_sync.v]
// Two flip-flop synchroniser for a bus of unrelated levels
`timescale 1ns/10ps
module cog_sync #(
   parameter W = 1
) (
   input  wire         core_clk,
   input  wire         rst_b,
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_q;  // First stage, read by second only
   reg [W-1:0] sync_q;  // Second stage, safe to use

   // ==========================================
   // Two stages on the core clock
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule // cog_sync

// [rtl/cog_gate.v]
// Glitch-free gate for one output clock, parked low when stopped
`timescale 1ns/10ps
module cog_gate (
   input  wire core_clk,
   input  wire rst_b,
   input  wire src_s,
   input  wire pin_en,
   input  wire bit_en,
   output wire clk_out
);
   reg gate_q;  // Enable as seen by the output
   reg out_q;   // Registered gated clock

   // ==========================================
   // Enable is only taken while the source is low,
   // so a pulse is never cut short or stretched
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         gate_q <= 1'b0;
         out_q  <= 1'b0;
      end else begin
         if (!src_s) begin
            // Both pin and bit must be high
            gate_q <= pin_en & bit_en;
         end
         // Stopped output sits low
         out_q <= src_s & gate_q;
      end
   end

   assign clk_out = out_q;
endmodule // cog_gate

// [rtl/cog_top.v]
// Gated two-output clock fanout with serial control registers
`timescale 1ns/10ps
`include "cog_map.vh"
module cog_top #(
   parameter [3:0] REV_CODE   = 4'h1, // Arbitrary value
   parameter [3:0] MAKER_CODE = 4'h5  // Arbitrary value
) (
   input  wire core_clk,
   input  wire rst_b,
   input  wire clk_src,
   input  wire out_zero_en_pin,
   input  wire out_one_en_pin,
   input  wire prog_mode,
   input  wire scl_i,
   input  wire sda_i,
   output wire sda_o,
   output wire sda_oe,
   output wire clock_out_zero,
   output wire clock_out_one
);
   // ==========================================
   // Slave states
   localparam [2:0] S_IDLE = 3'h0; // Not addressed
   localparam [2:0] S_RX   = 3'h1; // Taking a byte
   localparam [2:0] S_ACK  = 3'h2; // Driving ACK
   localparam [2:0] S_TX   = 3'h3; // Sending a byte
   localparam [2:0] S_RACK = 3'h4; // Host ACK slot

   // ==========================================
   // Synchronised pins
   wire [5:0] pin_s;      // All pin levels after two flops
   wire       src_s;      // Source clock level
   wire       zero_pin_s; // Enable pin, output zero
   wire       one_pin_s;  // Enable pin, output one
   wire       prog_s;     // Program mode level
   wire       scl_s;      // Serial clock level
   wire       sda_s;      // Serial data level

   cog_sync #(
      .W(6)
   ) u_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .async_in ({clk_src, out_zero_en_pin, out_one_en_pin,
                  prog_mode, scl_i, sda_i}),
      .sync_out (pin_s)
   );

   assign src_s      = pin_s[5];
   assign zero_pin_s = pin_s[4]; // Host keeps it driven
   assign one_pin_s  = pin_s[3]; // Host keeps it driven
   assign prog_s     = pin_s[2];
   assign scl_s      = pin_s[1];
   assign sda_s      = pin_s[0];

   // ==========================================
   // Registers
   reg [7:0] rsvd_a_q;   // Index 0
   reg [7:0] rsvd_b_q;   // Index 1
   reg [7:0] gate_q;     // Index 2, output enables
   reg [7:0] len_q;      // Index 4, transfer length
   // Slave state
   reg [2:0] state_q;    // Current slave state
   reg [2:0] bit_q;      // Bit within byte
   reg       full_q;     // Eight bits taken
   reg [7:0] sh_q;       // Shift register
   reg [1:0] byte_q;     // Byte number, saturates
   reg       rw_q;       // Read direction
   reg       blk_q;      // Block access
   reg       cnt_q;      // Count byte still to send
   reg [6:0] ptr_q;      // Register pointer
   reg       oe_q;       // Data line pulled low
   reg       scl_d1_q;   // Serial clock, last cycle
   reg       sda_d1_q;   // Serial data, last cycle
   reg [1:0] warm_q;     // Cycles since reset, saturates

   // ==========================================
   // Read decode, used for every read byte but the count byte
   function [7:0] rd_sel;
      input [6:0] idx;
      begin
         case (idx)
            `COG_IDX_RSVD_A: rd_sel = rsvd_a_q;
            `COG_IDX_RSVD_B: rd_sel = rsvd_b_q;
            `COG_IDX_GATE:   rd_sel = gate_q;
            // Fixed codes, writes are dropped
            `COG_IDX_REV:    rd_sel = {REV_CODE, MAKER_CODE};
            `COG_IDX_LEN:    rd_sel = len_q;
            default:         rd_sel = 8'h00;
         endcase
      end
   endfunction

   // Byte under the pointer, loaded into the shifter
   wire [7:0] rd_byte;  // Next read byte
   assign rd_byte = rd_sel(ptr_q);

   // ==========================================
   // Bus events
   wire scl_rise;  // Sample point
   wire scl_fall;  // Drive point
   wire start_det; // Start or repeated start
   wire stop_det;  // Stop
   wire addr_hit;  // Own address seen
   wire bus_live;  // Synchroniser holds real pin levels

   // ==========================================
   // Warm-up after reset: the synchroniser starts low while the
   // idle bus sits high, which would read as a false edge, so bus
   // events are ignored until both stages have filled
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         warm_q <= 2'h0;
      end else if (warm_q != 2'h3) begin
         // Count up, then hold
         warm_q <= warm_q + 2'h1;
      end
   end

   assign bus_live  = (warm_q == 2'h3);
   assign scl_rise  = bus_live & scl_s & ~scl_d1_q;
   assign scl_fall  = bus_live & ~scl_s & scl_d1_q;
   // Both lines read the same cycle, so the
   // edges are judged with scl held high
   assign start_det = bus_live & scl_s & scl_d1_q & sda_d1_q & ~sda_s;
   assign stop_det  = bus_live & scl_s & scl_d1_q & ~sda_d1_q & sda_s;
   // Compare upper seven bits only
   assign addr_hit  = (sh_q[7:1] == `COG_SLAVE_ADDR);

   // ==========================================
   // Register writes from the slave
   wire       wr_hit;  // Data byte lands
   wire [6:0] wr_idx;  // Where it lands

   assign wr_hit = (state_q == S_RX) & full_q & scl_fall
                 & (byte_q == 2'h3) & ~rw_q;
   assign wr_idx = ptr_q;

   // Register file; all defaults at reset
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rsvd_a_q <= `COG_RST_RSVD_A;
         rsvd_b_q <= `COG_RST_RSVD_B;
         gate_q   <= `COG_RST_GATE;
         len_q    <= `COG_RST_LEN;
      end else if (wr_hit) begin
         case (wr_idx)
            `COG_IDX_RSVD_A: rsvd_a_q <= sh_q;
            `COG_IDX_RSVD_B: rsvd_b_q <= sh_q;
            `COG_IDX_GATE: begin
               // Output enables only in program mode
               if (prog_s) begin
                  gate_q <= sh_q;
               end
            end
            `COG_IDX_LEN:    len_q <= sh_q;
            default: ;
         endcase
      end
   end

   // ==========================================
   // Serial slave state machine
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q  <= S_IDLE;
         bit_q    <= 3'h0;
         full_q   <= 1'b0;
         sh_q     <= 8'h00;
         byte_q   <= 2'h0;
         rw_q     <= 1'b0;
         blk_q    <= 1'b0;
         cnt_q    <= 1'b0;
         ptr_q    <= 7'h00;
         oe_q     <= 1'b0;
         scl_d1_q <= 1'b1;
         sda_d1_q <= 1'b1;
      end else begin
         scl_d1_q <= scl_s;
         sda_d1_q <= sda_s;
         if (stop_det) begin
            // Stop ends any transfer
            state_q <= S_IDLE;
            oe_q    <= 1'b0;
         end else if (start_det) begin
            // Repeated start keeps the pointer
            state_q <= S_RX;
            bit_q   <= 3'h0;
            full_q  <= 1'b0;
            byte_q  <= 2'h0;
            oe_q    <= 1'b0;
         end else begin
            case (state_q)
               S_IDLE: begin
                  oe_q <= 1'b0;
               end
               S_RX: begin
                  if (scl_rise) begin
                     // MSB arrives first
                     sh_q   <= {sh_q[6:0], sda_s};
                     bit_q  <= bit_q + 3'h1;
                     full_q <= (bit_q == 3'h7);
                  end else if (scl_fall && full_q) begin
                     full_q <= 1'b0;
                     case (byte_q)
                        2'h0: begin
                           if (addr_hit) begin
                              rw_q    <= sh_q[0];
                              oe_q    <= 1'b1;
                              state_q <= S_ACK;
                              byte_q  <= 2'h1;
                              // Block read starts with count
                              cnt_q   <= blk_q;
                           end else begin
                              // Stay off the line
                              state_q <= S_IDLE;
                           end
                        end
                        2'h1: begin
                           // Index, then kind of access
                           ptr_q   <= sh_q[6:0];
                           blk_q   <= ~sh_q[`COG_CMD_BYTE_BIT];
                           byte_q  <= sh_q[`COG_CMD_BYTE_BIT]
                                    ? 2'h3 : 2'h2;
                           oe_q    <= 1'b1;
                           state_q <= S_ACK;
                        end
                        2'h2: begin
                           // Count byte taken and not used
                           byte_q  <= 2'h3;
                           oe_q    <= 1'b1;
                           state_q <= S_ACK;
                        end
                        default: begin
                           // Data stored, pointer climbs
                           ptr_q   <= ptr_q + 7'h01;
                           oe_q    <= 1'b1;
                           state_q <= S_ACK;
                        end
                     endcase
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     bit_q <= 3'h0;
                     if (rw_q) begin
                        // First read byte goes out at once
                        state_q <= S_TX;
                        if (cnt_q) begin
                           sh_q  <= len_q;
                           cnt_q <= 1'b0;
                           oe_q  <= ~len_q[7];
                        end else begin
                           sh_q  <= rd_byte;
                           ptr_q <= ptr_q + 7'h01;
                           oe_q  <= ~rd_byte[7];
                        end
                     end else begin
                        state_q <= S_RX;
                        oe_q    <= 1'b0;
                     end
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     if (bit_q == 3'h7) begin
                        // Let go for the host answer
                        oe_q    <= 1'b0;
                        state_q <= S_RACK;
                     end else begin
                        // Next bit, MSB first
                        sh_q  <= {sh_q[6:0], 1'b0};
                        oe_q  <= ~sh_q[6];
                        bit_q <= bit_q + 3'h1;
                     end
                  end
               end
               S_RACK: begin
                  if (scl_rise && sda_s) begin
                     // NACK closes the read
                     state_q <= S_IDLE;
                  end else if (scl_fall) begin
                     // ACK asks for the next byte
                     bit_q   <= 3'h0;
                     state_q <= S_TX;
                     sh_q    <= rd_byte;
                     ptr_q   <= ptr_q + 7'h01;
                     oe_q    <= ~rd_byte[7];
                  end
               end
               default: begin
                  state_q <= S_IDLE;
                  oe_q    <= 1'b0;
               end
            endcase
         end
      end
   end

   // Open drain: only ever pulls low
   assign sda_o  = 1'b0;
   assign sda_oe = oe_q;

   // ==========================================
   // Output gates, one per clock
   cog_gate u_gate_zero (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .src_s    (src_s),
      .pin_en   (zero_pin_s),
      .bit_en   (gate_q[`COG_BIT_OUT_ZERO]),
      .clk_out  (clock_out_zero)
   );

   cog_gate u_gate_one (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .src_s    (src_s),
      .pin_en   (one_pin_s),
      .bit_en   (gate_q[`COG_BIT_OUT_ONE]),
      .clk_out  (clock_out_one)
   );
endmodule // cog_top

// [sim/cog_top_assertions.sv]
// Port checker for the gated clock fanout block
`timescale 1ns/10ps
module cog_top_checker (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_src,
   input wire logic out_zero_en_pin,
   input wire logic out_one_en_pin,
   input wire logic prog_mode,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic clock_out_zero,
   input wire logic clock_out_one
);
   // ====================
   // Cycles each enable pin has been low, saturating
   logic [5:0] lo0_q;
   logic [5:0] lo1_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         lo0_q <= 6'h00;
         lo1_q <= 6'h00;
      end else begin
         lo0_q <= out_zero_en_pin ? 6'h00 : lo0_q + {5'h00, ~&lo0_q};
         lo1_q <= out_one_en_pin ? 6'h00 : lo1_q + {5'h00, ~&lo1_q};
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // A level held for six cycles: one clean phase of the output
   sequence s_hold(logic s);
      s [*6];
   endsequence
   property p_zero_parks;
      (lo0_q > 6'h28) |-> !clock_out_zero;
   endproperty
   property p_one_parks;
      (lo1_q > 6'h28) |-> !clock_out_one;
   endproperty
   property p_zero_full;
      $rose(clock_out_zero) |=> s_hold(clock_out_zero);
   endproperty
   property p_one_full_low;
      $fell(clock_out_one) |=> s_hold(!clock_out_one);
   endproperty
   property p_zero_pin;
      $rose(clock_out_zero) |-> $past(out_zero_en_pin, 3);
   endproperty
   property p_one_pin;
      $rose(clock_out_one) |-> $past(out_one_en_pin, 3);
   endproperty
   // Data may only move while the serial clock is low
   property p_sda_quiet;
      $changed(sda_oe) |-> !scl_i;
   endproperty
   property p_ack_stands;
      $rose(sda_oe) |=> s_hold(sda_oe);
   endproperty
   property p_reset_quiet;
      $rose(rst_b) |-> !sda_oe && !clock_out_zero && !clock_out_one;
   endproperty
   a_zero_parks: assert property (p_zero_parks) else $error("out zero not parked low");
   a_one_parks: assert property (p_one_parks) else $error("out one not parked low");
   a_zero_full: assert property (p_zero_full) else $error("out zero short pulse");
   a_one_full_low: assert property (p_one_full_low) else $error("out one short low");
   a_zero_pin: assert property (p_zero_pin) else $error("out zero ran with pin low");
   a_one_pin: assert property (p_one_pin) else $error("out one ran with pin low");
   a_sda_quiet: assert property (p_sda_quiet) else $error("data moved with scl high");
   a_ack_stands: assert property (p_ack_stands) else $error("ack too short");
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy at reset");
endmodule // cog_top_checker
bind cog_top cog_top_checker i_chk (.core_clk(core_clk), .rst_b(rst_b), .clk_src(clk_src),
   .out_zero_en_pin(out_zero_en_pin), .out_one_en_pin(out_one_en_pin),
   .prog_mode(prog_mode), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .clock_out_zero(clock_out_zero), .clock_out_one(clock_out_one));

// [sim/cog_host.sv]
// Two-wire host and enable-pin driver model
`timescale 1ns/10ps
module cog_host (
   input  wire logic core_clk,
   input  wire logic sda_oe,
   output logic      scl_q,
   output wire logic sda_w,
   output logic      pin0_q,
   output logic      pin1_q
);
   // ====================
   logic sda_q;                          // Host drive, 1 = released
   // Pull-up: the wire is low if either party pulls
   assign sda_w = sda_q & ~sda_oe;
   initial begin
      scl_q = 1'b1;
      sda_q = 1'b1;
      pin0_q = 1'b1;                     // Pins driven from time zero
      pin1_q = 1'b1;
   end
   task automatic hp(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic set_pins(input logic z, input logic o);
      @(posedge core_clk);
      pin0_q <= z;
      pin1_q <= o;
   endtask
   // Start, also used as repeated start
   task automatic start_c();
      hp(3);
      sda_q <= 1'b1;
      hp(10);
      scl_q <= 1'b1;
      hp(10);
      sda_q <= 1'b0;
      hp(10);
      scl_q <= 1'b0;
   endtask
   task automatic stop_c();
      hp(3);
      sda_q <= 1'b0;
      hp(10);
      scl_q <= 1'b1;
      hp(10);
      sda_q <= 1'b1;
      hp(10);
   endtask
   // Data set well after the scl fall to keep hold time
   task automatic xbit(input logic b, output logic r);
      hp(3);
      sda_q <= b;
      hp(10);
      scl_q <= 1'b1;
      hp(10);
      r = sda_w;
      scl_q <= 1'b0;
   endtask
   // Eight bits most significant first, then the ack slot
   task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] r,
                        output logic ar);
      for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
      xbit(ab, ar);                      // Host ack or not-ack
   endtask
endmodule // cog_host

// [sim/testbench.sv]
// Self-checking bench of the gated clock fanout block
`timescale 1ns/10ps
module testbench;
   // ====================
   logic       core_clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       clk_src = 1'b0;
   logic       prog_mode = 1'b1;
   logic       scl, sda, pin0, pin1, sda_o, sda_oe, out0, out1;
   logic [15:0] rnd_q = 16'h7cb8;        // Fixed seed, 31928
   logic [7:0] mem [0:4];                // Expected register image
   logic [7:0] v;
   logic       a;
   int         fail_count = 0;
   int         checks_done = 0;
   int         e0, e1, j;
   logic [9:0] gc [0:6] = '{10'h3c0, 10'h1c0, 10'h2c0, 10'h340, 10'h380, 10'h300, 10'h3c0};
   always #4 core_clk = ~core_clk;
   initial #3 forever #62.5 clk_src = ~clk_src;
   cog_top #(.REV_CODE(4'ha), .MAKER_CODE(4'h3)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
      .clk_src(clk_src), .out_zero_en_pin(pin0), .out_one_en_pin(pin1), .prog_mode(prog_mode),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .clock_out_zero(out0),
      .clock_out_one(out1));
   cog_host i_host (.core_clk(core_clk), .sda_oe(sda_oe), .scl_q(scl), .sda_w(sda),
      .pin0_q(pin0), .pin1_q(pin1));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] cls(input int e);
      return (e >= 7) ? 8'h01 : ((e == 0) ? 8'h00 : 8'hee);
   endfunction
   function automatic logic [7:0] exp_run(input logic p, input logic b);
      return {7'h00, p & b};
   endfunction
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [6:0] idx, input logic [7:0] d);
      logic a0, a1, a2;
      i_host.start_c();
      i_host.xbyte(8'hd6, 1'b1, v, a0);
      i_host.xbyte({1'b1, idx}, 1'b1, v, a1);
      i_host.xbyte(d, 1'b1, v, a2);
      i_host.stop_c();
      check("wr_ack", {5'h00, a0, a1, a2}, 8'h00);
   endtask
   task automatic rd(input logic [6:0] idx, output logic [7:0] d);
      logic a0, a1, a2, n;
      i_host.start_c();
      i_host.xbyte(8'hd6, 1'b1, v, a0);
      i_host.xbyte({1'b1, idx}, 1'b1, v, a1);
      i_host.start_c();
      i_host.xbyte(8'hd7, 1'b1, v, a2);
      i_host.xbyte(8'hff, 1'b1, d, n);
      i_host.stop_c();
      check("rd_ack", {5'h00, a0, a1, a2}, 8'h00);
   endtask
   // Rising edges of both outputs over n cycles, sampled off the edge
   task automatic runs(input int n);
      logic p0, p1;
      p0 = out0;
      p1 = out1;
      e0 = 0;
      e1 = 0;
      repeat (n) begin
         @(negedge core_clk);
         e0 += int'(out0 === 1'b1 && p0 === 1'b0);
         e1 += int'(out1 === 1'b1 && p1 === 1'b0);
         p0 = out0;
         p1 = out1;
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Watchdog: about three times the expected run
   initial begin
      #600000;
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge core_clk);
      mem = '{8'h00, 8'h00, 8'hc0, 8'ha3, 8'h06};
      for (int i = 0; i < 5; i++) begin
         rd(7'(i), v);
         check("reset_val", v, mem[i]);
      end
      // Random single-byte traffic on the writable plain registers
      for (int i = 0; i < 6; i++) begin
         rnd_q = lfsr(rnd_q);
         j = (i % 3 == 2) ? 4 : i % 3;
         wr(7'(j), rnd_q[7:0]);
         mem[j] = rnd_q[7:0];
         rd(7'(j), v);
         check("byte_rw", v, mem[j]);
      end
      // Gate register locked outside program mode
      @(posedge core_clk) prog_mode <= 1'b0;
      wr(7'h02, 8'h3f);
      rd(7'h02, v);
      check("prog_lock", v, mem[2]);
      @(posedge core_clk) prog_mode <= 1'b1;
      // Foreign address is left alone
      i_host.start_c();
      i_host.xbyte(8'ha4, 1'b1, v, a);
      i_host.stop_c();
      check("foreign_ack", {7'h00, a}, 8'h01);
      check("sda_o_low", {7'h00, sda_o}, 8'h00);
      // Block write from index 0, enables kept on
      i_host.start_c();
      i_host.xbyte(8'hd6, 1'b1, v, a);
      i_host.xbyte(8'h00, 1'b1, v, a);
      i_host.xbyte(8'h03, 1'b1, v, a);
      for (int i = 0; i < 3; i++) begin
         rnd_q = lfsr(rnd_q);
         mem[i] = (i == 2) ? {2'b11, rnd_q[5:0]} : rnd_q[7:0];
         i_host.xbyte(mem[i], 1'b1, v, a);
         check("blk_ack", {7'h00, a}, 8'h00);
      end
      i_host.stop_c();
      // Block read back, not-ack on the last byte
      i_host.start_c();
      i_host.xbyte(8'hd6, 1'b1, v, a);
      i_host.xbyte(8'h00, 1'b1, v, a);
      i_host.start_c();
      i_host.xbyte(8'hd7, 1'b1, v, a);
      i_host.xbyte(8'hff, 1'b0, v, a);
      check("blk_count", v, mem[4]);
      for (int i = 0; i < 3; i++) begin
         i_host.xbyte(8'hff, i == 2, v, a);
         check("blk_data", v, mem[i]);
      end
      i_host.stop_c();
      // Pin and bit combinations, settle six output periods first
      for (int i = 0; i < 7; i++) begin
         rnd_q = lfsr(rnd_q);
         v = {gc[i][7:6], rnd_q[5:0]};
         wr(7'h02, v);
         i_host.set_pins(gc[i][9], gc[i][8]);
         repeat (96) @(posedge core_clk);
         runs(128);
         check("out_zero", cls(e0), exp_run(gc[i][9], v[7]));
         check("out_one", cls(e1), exp_run(gc[i][8], v[6]));
      end
      finish_test();
   end
endmodule // testbench
